/* sraf_map.vh */
/*
 Constants of the serial register access front end: command byte fields,
 register selects and widths, reset values and counts.
 Assumes nothing; definitions only.
*/
`ifndef SRAF_MAP_VH
`define SRAF_MAP_VH

// Command byte field positions.
`define SRAF_CMD_GATE_BIT 7
`define SRAF_CMD_DIR_BIT 6
`define SRAF_CMD_SEL_MSB 5
`define SRAF_CMD_SEL_LSB 3
`define SRAF_CMD_CONT_BIT 2

// Register selects.
`define SRAF_SEL_CMD_STAT 3'h0
`define SRAF_SEL_OPCTL 3'h1
`define SRAF_SEL_CHSET 3'h2
`define SRAF_SEL_RESULT 3'h3
`define SRAF_SEL_IDENT 3'h4
`define SRAF_SEL_PINCUR 3'h5
`define SRAF_SEL_ZCAL 3'h6
`define SRAF_SEL_GCAL 3'h7

// Register widths in bits.
`define SRAF_W8 5'h08
`define SRAF_W16 5'h10
`define SRAF_W24 5'h18

// Reset values.
`define SRAF_RST_OPCTL 16'h000A
`define SRAF_RST_CHSET 16'h0000
`define SRAF_RST_PINCUR 8'h00
`define SRAF_RST_ZCAL 24'h000000
`define SRAF_RST_GCAL 24'h000000
`define SRAF_RST_RESULT 24'h000000

// Continuous read exit byte, line-reset count and command bit count.
`define SRAF_CONT_EXIT 8'h58
`define SRAF_ONES_RESET 6'h20
`define SRAF_CMD_BITS 3'h7

`endif

/* sraf_sync.v */
/*
 Two-flop synchroniser for one level from outside the core clock domain.
 Assumes the input may change at any time relative to core_clk.
*/
`default_nettype none

module sraf_sync #(
   // Level held during reset; match the pin's idle level so no false edge follows.
   parameter [0:0] RST_VAL = 1'b0
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Level in and out
   input wire async_in,
   output reg sync_out_ff
);

   reg meta_ff;

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_ff <= RST_VAL;
         sync_out_ff <= RST_VAL;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out_ff <= meta_ff;
      end
   end

endmodule // sraf_sync

`default_nettype wire

/* sraf_ones_cnt.v */
/*
 Counter of consecutive ones sampled on the serial input.
 Assumes sample_en is a one-cycle pulse at each serial clock rising edge.
*/
`default_nettype none
`include "sraf_map.vh"

module sraf_ones_cnt (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Sampled serial bit
   input wire sample_en,
   input wire bit_in,
   // One-cycle pulse after the 32nd one of a run of ones
   output reg hit_ff
);

   reg [5:0] cnt_ff;
   reg [5:0] nxt_cnt;
   reg nxt_hit;

   always @*
   begin
      nxt_cnt = cnt_ff;
      nxt_hit = 1'b0;
      if (sample_en)
      begin
         if (!bit_in)
            nxt_cnt = 6'h00;
         else if (cnt_ff == `SRAF_ONES_RESET - 6'h01)
         begin
            nxt_cnt = 6'h00;
            nxt_hit = 1'b1;
         end
         else
            nxt_cnt = cnt_ff + 6'h01;
      end
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_ff <= 6'h00;
         hit_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         hit_ff <= nxt_hit;
      end
   end

endmodule // sraf_ones_cnt

`default_nettype wire

/* sraf_frontend.v */
/*
 Serial command front end: decodes the command byte, shifts register
 reads and writes, runs continuous result read and keeps the ready flag.
 Assumes the host drives the serial clock idle high, changes input data
 on falling edges and samples output data on rising edges.
*/
`default_nettype none
`include "sraf_map.vh"

module sraf_frontend #(
   // Arbitrary identity value.
   parameter [7:0] PART_ID = 8'h5A,
   parameter [0:0] STATUS_BIT3 = 1'b1
) (
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Serial pins
   input wire sclk_pin,
   input wire din_pin,
   output reg dout_rdy_ff,
   // Converter side
   input wire result_valid,
   input wire [23:0] result_data,
   input wire result_pending,
   input wire power_down,
   input wire conv_error,
   input wire no_ref,
   input wire [2:0] active_channel,
   // Control outputs
   output reg ready_n_ff,
   output reg mod_reset_ff,
   output reg part_reset_ff,
   output reg cont_read_ff,
   output reg [15:0] operating_control_ff,
   output reg [15:0] channel_setup_ff,
   output reg [7:0] pin_current_control_ff,
   output reg [23:0] zero_calibration_ff,
   output reg [23:0] gain_calibration_ff
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CMD = 3'h1;
   localparam [2:0] ST_WR = 3'h2;
   localparam [2:0] ST_RD = 3'h3;
   localparam [2:0] ST_CONT = 3'h4;

   wire sclk_s;
   wire din_s;
   wire ones_hit;
   reg sclk_d_ff;
   wire sclk_rise;
   wire sclk_fall;

   sraf_sync #(.RST_VAL(1'b1)) u_sync_sclk (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(sclk_pin),
      .sync_out_ff(sclk_s)
   );

   sraf_sync u_sync_din (
      .core_clk(core_clk),
      .nrst(nrst),
      .async_in(din_pin),
      .sync_out_ff(din_s)
   );

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         sclk_d_ff <= 1'b1;
      else
         sclk_d_ff <= sclk_s;
   end

   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign sclk_fall = ~sclk_s & sclk_d_ff;

   // The ones counter runs in every state, continuous read included.
   sraf_ones_cnt u_ones (
      .core_clk(core_clk),
      .nrst(nrst),
      .sample_en(sclk_rise),
      .bit_in(din_s),
      .hit_ff(ones_hit)
   );

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [6:0] cmd_sh_ff;
   reg [6:0] nxt_cmd_sh;
   reg [2:0] sel_ff;
   reg [2:0] nxt_sel;
   reg [4:0] bit_cnt_ff;
   reg [4:0] nxt_bit_cnt;
   reg [4:0] width_ff;
   reg [4:0] nxt_width;
   reg [23:0] sh_ff;
   reg [23:0] nxt_sh;
   reg [23:0] rd_word_ff;
   reg [23:0] nxt_rd_word;
   reg [7:0] mon_ff;
   reg [7:0] nxt_mon;
   reg [23:0] result_ff;
   reg nxt_dout;
   reg nxt_cont;
   reg wr_commit;
   reg rd_done;

   wire [7:0] status_word;
   wire [7:0] cmd_full;
   wire [2:0] cmd_sel;
   wire [7:0] mon_next;

   assign status_word = {ready_n_ff, conv_error, no_ref, 1'b0, STATUS_BIT3, active_channel};
   assign cmd_full = {1'b0, cmd_sh_ff[5:0], din_s};
   assign cmd_sel = cmd_full[`SRAF_CMD_SEL_MSB:`SRAF_CMD_SEL_LSB];
   assign mon_next = {mon_ff[6:0], din_s};

   // Register width for a select.
   function [4:0] sel_width;
      input [2:0] sel;
      begin
         case (sel)
            `SRAF_SEL_OPCTL,
            `SRAF_SEL_CHSET: sel_width = `SRAF_W16;
            `SRAF_SEL_RESULT,
            `SRAF_SEL_ZCAL,
            `SRAF_SEL_GCAL: sel_width = `SRAF_W24;
            default: sel_width = `SRAF_W8;
         endcase
      end
   endfunction

   // Read value aligned so its first bit sits at bit 23.
   function [23:0] sel_value;
      input [2:0] sel;
      begin
         case (sel)
            `SRAF_SEL_CMD_STAT: sel_value = {status_word, 16'h0000};
            `SRAF_SEL_OPCTL: sel_value = {operating_control_ff, 8'h00};
            `SRAF_SEL_CHSET: sel_value = {channel_setup_ff, 8'h00};
            `SRAF_SEL_RESULT: sel_value = result_ff;
            `SRAF_SEL_IDENT: sel_value = {PART_ID, 16'h0000};
            `SRAF_SEL_PINCUR: sel_value = {pin_current_control_ff, 16'h0000};
            `SRAF_SEL_ZCAL: sel_value = zero_calibration_ff;
            `SRAF_SEL_GCAL: sel_value = gain_calibration_ff;
            default: sel_value = 24'h000000;
         endcase
      end
   endfunction

   always @*
   begin
      nxt_state = state_ff;
      nxt_cmd_sh = cmd_sh_ff;
      nxt_sel = sel_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_width = width_ff;
      nxt_sh = sh_ff;
      nxt_rd_word = rd_word_ff;
      nxt_mon = mon_ff;
      nxt_cont = cont_read_ff;
      nxt_dout = dout_rdy_ff;
      wr_commit = 1'b0;
      rd_done = 1'b0;
      case (state_ff)
         ST_IDLE:
         begin
            // Outside a read the output pin mirrors the ready flag.
            nxt_dout = ready_n_ff;
            if (sclk_rise && !din_s)
            begin
               nxt_state = ST_CMD;
               nxt_bit_cnt = 5'h00;
            end
         end
         ST_CMD:
         begin
            nxt_dout = ready_n_ff;
            if (sclk_rise)
            begin
               nxt_cmd_sh = {cmd_sh_ff[5:0], din_s};
               nxt_bit_cnt = bit_cnt_ff + 5'h01;
               if (bit_cnt_ff == {2'b00, `SRAF_CMD_BITS} - 5'h01)
               begin
                  nxt_sel = cmd_sel;
                  nxt_width = sel_width(cmd_sel);
                  nxt_bit_cnt = 5'h00;
                  nxt_sh = 24'h000000;
                  nxt_rd_word = sel_value(cmd_sel);
                  if (!cmd_full[`SRAF_CMD_DIR_BIT])
                  begin
                     // Writing the command register just waits for another.
                     if (cmd_sel == `SRAF_SEL_CMD_STAT)
                        nxt_state = ST_IDLE;
                     else
                        nxt_state = ST_WR;
                  end
                  else if (cmd_full[`SRAF_CMD_CONT_BIT] && cmd_sel == `SRAF_SEL_RESULT)
                  begin
                     nxt_state = ST_CONT;
                     nxt_cont = 1'b1;
                     nxt_mon = 8'h00;
                  end
                  else
                     nxt_state = ST_RD;
               end
            end
         end
         ST_WR:
         begin
            nxt_dout = ready_n_ff;
            if (sclk_rise)
            begin
               nxt_sh = {sh_ff[22:0], din_s};
               nxt_bit_cnt = bit_cnt_ff + 5'h01;
               if (bit_cnt_ff == width_ff - 5'h01)
               begin
                  wr_commit = 1'b1;
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_RD:
         begin
            if (sclk_fall)
            begin
               nxt_dout = rd_word_ff[23];
               nxt_rd_word = {rd_word_ff[22:0], 1'b0};
            end
            if (sclk_rise)
            begin
               nxt_bit_cnt = bit_cnt_ff + 5'h01;
               if (bit_cnt_ff == width_ff - 5'h01)
               begin
                  rd_done = (sel_ff == `SRAF_SEL_RESULT);
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_CONT:
         begin
            if (sclk_fall)
            begin
               if (bit_cnt_ff == 5'h00)
               begin
                  nxt_dout = result_ff[23];
                  nxt_rd_word = {result_ff[22:0], 1'b0};
               end
               else
               begin
                  nxt_dout = rd_word_ff[23];
                  nxt_rd_word = {rd_word_ff[22:0], 1'b0};
               end
            end
            else if (bit_cnt_ff == 5'h00 && !sclk_rise)
               nxt_dout = ready_n_ff;
            if (sclk_rise)
            begin
               // Input is watched for the exit byte in the first eight bits of each word.
               nxt_mon = mon_next;
               nxt_bit_cnt = bit_cnt_ff + 5'h01;
               if (bit_cnt_ff == 5'h07 && mon_next == `SRAF_CONT_EXIT && !ready_n_ff)
               begin
                  nxt_state = ST_IDLE;
                  nxt_cont = 1'b0;
                  nxt_bit_cnt = 5'h00;
               end
               else if (bit_cnt_ff == `SRAF_W24 - 5'h01)
               begin
                  rd_done = 1'b1;
                  nxt_bit_cnt = 5'h00;
               end
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
            nxt_cont = 1'b0;
         end
      endcase
      if (ones_hit)
      begin
         nxt_state = ST_IDLE;
         nxt_cont = 1'b0;
         nxt_bit_cnt = 5'h00;
         nxt_dout = 1'b1;
      end
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= ST_IDLE;
         cmd_sh_ff <= 7'h00;
         sel_ff <= 3'h0;
         bit_cnt_ff <= 5'h00;
         width_ff <= `SRAF_W8;
         sh_ff <= 24'h000000;
         rd_word_ff <= 24'h000000;
         mon_ff <= 8'h00;
         cont_read_ff <= 1'b0;
         dout_rdy_ff <= 1'b1;
      end
      else
      begin
         state_ff <= nxt_state;
         cmd_sh_ff <= nxt_cmd_sh;
         sel_ff <= nxt_sel;
         bit_cnt_ff <= nxt_bit_cnt;
         width_ff <= nxt_width;
         sh_ff <= nxt_sh;
         rd_word_ff <= nxt_rd_word;
         mon_ff <= nxt_mon;
         cont_read_ff <= nxt_cont;
         dout_rdy_ff <= nxt_dout;
      end
   end

   // Register file; a line reset restores every default like power-up.
   wire wr_opctl;
   assign wr_opctl = wr_commit && sel_ff == `SRAF_SEL_OPCTL;

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         operating_control_ff <= `SRAF_RST_OPCTL;
         channel_setup_ff <= `SRAF_RST_CHSET;
         pin_current_control_ff <= `SRAF_RST_PINCUR;
         zero_calibration_ff <= `SRAF_RST_ZCAL;
         gain_calibration_ff <= `SRAF_RST_GCAL;
         result_ff <= `SRAF_RST_RESULT;
         mod_reset_ff <= 1'b0;
         part_reset_ff <= 1'b0;
      end
      else if (ones_hit)
      begin
         operating_control_ff <= `SRAF_RST_OPCTL;
         channel_setup_ff <= `SRAF_RST_CHSET;
         pin_current_control_ff <= `SRAF_RST_PINCUR;
         zero_calibration_ff <= `SRAF_RST_ZCAL;
         gain_calibration_ff <= `SRAF_RST_GCAL;
         result_ff <= `SRAF_RST_RESULT;
         mod_reset_ff <= 1'b1;
         part_reset_ff <= 1'b1;
      end
      else
      begin
         mod_reset_ff <= wr_opctl;
         part_reset_ff <= 1'b0;
         if (result_valid)
            result_ff <= result_data;
         if (wr_commit)
         begin
            // Result and identity are read-only; writes to them are dropped.
            case (sel_ff)
               `SRAF_SEL_OPCTL: operating_control_ff <= nxt_sh[15:0];
               `SRAF_SEL_CHSET: channel_setup_ff <= nxt_sh[15:0];
               `SRAF_SEL_PINCUR: pin_current_control_ff <= nxt_sh[7:0];
               `SRAF_SEL_ZCAL: zero_calibration_ff <= nxt_sh;
               `SRAF_SEL_GCAL: gain_calibration_ff <= nxt_sh;
               default: ;
            endcase
         end
      end
   end

   // Ready flag. A new result wins over a same-cycle raise from rd_done or result_pending,
   // but not over power_down, wr_opctl or a line reset, so a result arriving as a read ends is never hidden from the host.
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         ready_n_ff <= 1'b1;
      else if (ones_hit)
         ready_n_ff <= 1'b1;
      else if (result_valid && !power_down && !wr_opctl)
         ready_n_ff <= 1'b0;
      else if (rd_done || result_pending || power_down || wr_opctl)
         ready_n_ff <= 1'b1;
   end

endmodule // sraf_frontend

`default_nettype wire

/* sraf_frontend_sva.sv */
/*
 Port checker for the serial register access front end.
 Assumes it is bound to sraf_frontend, whose reset nrst is async active low.
*/
`default_nettype none
`include "sraf_map.vh"

module sraf_frontend_sva (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Serial and converter side
   input wire logic sclk_pin,
   input wire logic dout_rdy_ff,
   input wire logic result_valid,
   input wire logic power_down,
   // Flags and registers
   input wire logic ready_n_ff,
   input wire logic mod_reset_ff,
   input wire logic part_reset_ff,
   input wire logic cont_read_ff,
   input wire logic [15:0] operating_control_ff,
   input wire logic [15:0] channel_setup_ff,
   input wire logic [23:0] zero_calibration_ff
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // Eight cycles without a serial clock edge leave room for the edge detector delay.
   sequence sclk_quiet;
      $stable(sclk_pin) [*8];
   endsequence
   sequence line_reset;
      part_reset_ff ##0 mod_reset_ff;
   endsequence

   a_result_ready: assert property (
      result_valid && !power_down |=> !ready_n_ff || mod_reset_ff || part_reset_ff)
      else $error("ready flag did not fall after a new result");
   a_power_ready: assert property (power_down |=> ready_n_ff)
      else $error("ready flag low in power down");
   a_modrst_ready: assert property (mod_reset_ff |-> ready_n_ff)
      else $error("modulator reset without ready high");
   a_line_defaults: assert property (
      line_reset |-> dout_rdy_ff && ready_n_ff && !cont_read_ff
      && operating_control_ff == `SRAF_RST_OPCTL && channel_setup_ff == `SRAF_RST_CHSET)
      else $error("line reset did not restore defaults");
   a_partrst_pair: assert property (part_reset_ff |-> line_reset)
      else $error("part reset without modulator reset");
   a_pulse_single: assert property (mod_reset_ff |=> !mod_reset_ff)
      else $error("modulator reset longer than one cycle");
   a_opctl_modrst: assert property (
      $changed(operating_control_ff) && !part_reset_ff |-> mod_reset_ff)
      else $error("control write without modulator reset");
   a_quiet_regs: assert property (
      sclk_quiet |-> $stable(channel_setup_ff) && $stable(zero_calibration_ff)
      && $stable(cont_read_ff) && !part_reset_ff)
      else $error("register changed without serial clocks");
   a_quiet_dout: assert property (
      sclk_quiet ##0 !cont_read_ff |-> dout_rdy_ff == ready_n_ff
      || dout_rdy_ff == $past(ready_n_ff))
      else $error("idle output does not show ready");
   a_cont_exit: assert property (
      $fell(cont_read_ff) && !part_reset_ff |-> $past(ready_n_ff) == 1'b0)
      else $error("continuous read left while ready high");
endmodule // sraf_frontend_sva

bind sraf_frontend sraf_frontend_sva chk_u (.core_clk(core_clk), .nrst(nrst),
   .sclk_pin(sclk_pin), .dout_rdy_ff(dout_rdy_ff), .result_valid(result_valid),
   .power_down(power_down), .ready_n_ff(ready_n_ff), .mod_reset_ff(mod_reset_ff),
   .part_reset_ff(part_reset_ff), .cont_read_ff(cont_read_ff),
   .operating_control_ff(operating_control_ff), .channel_setup_ff(channel_setup_ff),
   .zero_calibration_ff(zero_calibration_ff));
`default_nettype wire

/* sraf_host.sv */
/*
 Host model driving the serial clock and data input of the front end.
 Assumes the front end answers within a half period of 32 ns.
*/
`default_nettype none

module sraf_host (
   // Serial pins
   output logic sclk_pin,
   output logic din_pin,
   input wire logic dout_rdy_ff
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      sclk_pin = 1'b1;
      din_pin = 1'b0;
   end

   // Data changes on the falling edge and output is taken on the rising edge.
   task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk_pin = 1'b0;
         din_pin = tx[i];
         #32;
         sclk_pin = 1'b1;
         rx = {rx[62:0], dout_rdy_ff};
         #32;
      end
      // Held low so that idle time never counts towards a line reset.
      din_pin = 1'b0;
      #100;
   endtask
endmodule // sraf_host
`default_nettype wire

/* test_serial_register_access_frontend.sv */
/*
 Self-checking bench for the serial register access front end.
 Assumes the host model and the bound checker are compiled alongside.
*/
`default_nettype none

module test_serial_register_access_frontend;
   timeunit 1ns;
   timeprecision 100ps;
   // Arbitrary identity value.
   localparam logic [7:0] ID_VAL = 8'h5A;
   logic core_clk, nrst, sclk_pin, din_pin, dout_rdy_ff, result_valid, result_pending;
   logic power_down, ready_n_ff, mod_reset_ff, part_reset_ff, cont_read_ff, pr_seen;
   logic [15:0] opctl, chset;
   logic [7:0] pincur;
   logic [23:0] result_data, zcal, gcal;
   logic [63:0] rx;
   logic [31:0] v;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   sraf_frontend #(.PART_ID(ID_VAL)) dut_u (.core_clk(core_clk), .nrst(nrst),
      .sclk_pin(sclk_pin), .din_pin(din_pin), .dout_rdy_ff(dout_rdy_ff),
      .result_valid(result_valid), .result_data(result_data),
      .result_pending(result_pending), .power_down(power_down), .conv_error(1'b1),
      .no_ref(1'b0), .active_channel(3'h5), .ready_n_ff(ready_n_ff),
      .mod_reset_ff(mod_reset_ff), .part_reset_ff(part_reset_ff),
      .cont_read_ff(cont_read_ff), .operating_control_ff(opctl), .channel_setup_ff(chset),
      .pin_current_control_ff(pincur), .zero_calibration_ff(zcal),
      .gain_calibration_ff(gcal));
   sraf_host host_u (.sclk_pin(sclk_pin), .din_pin(din_pin), .dout_rdy_ff(dout_rdy_ff));

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cycles++;
      if (part_reset_ff === 1'b1) pr_seen = 1'b1;
      if (cycles == 30000)
      begin
         $display("Error at %0t: run did not finish", $time);
         num_errors++;
         summarize();
      end
   end

   task summarize();
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
         num_errors++;
      end
   endtask

   // Command byte then w data bits in one unbroken frame.
   task wr(input logic [7:0] cmd, input int w, input logic [31:0] d);
      host_u.frame(({56'h0, cmd} << w) | {32'h0, d}, 8 + w, rx);
   endtask

   task rd(input logic [7:0] cmd, input int w, output logic [31:0] d);
      host_u.frame({56'h0, cmd} << w, 8 + w, rx);
      rx = rx & ((64'h1 << w) - 64'h1);
      d = rx[31:0];
   endtask

   task pulse_res(input logic [23:0] d);
      @(posedge core_clk);
      #1 result_valid = 1'b1;
      result_data = d;
      @(posedge core_clk);
      #1 result_valid = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   function logic [31:0] reg_of(input logic [2:0] sel);
      case (sel)
         3'h1: reg_of = {16'h0, opctl};
         3'h2: reg_of = {16'h0, chset};
         3'h5: reg_of = {24'h0, pincur};
         3'h6: reg_of = {8'h0, zcal};
         default: reg_of = {8'h0, gcal};
      endcase
   endfunction

   task test_defaults();
      chk({16'h0, opctl}, 32'h000A);
      chk({16'h0, chset}, 32'h0);
      rd(8'h48, 16, v);
      chk(v, 32'h000A);
      host_u.frame({45'h0, 3'b111, 8'h60, 8'h00}, 19, rx);
      chk(rx[31:0] & 32'hFF, {24'h0, ID_VAL});
      $display("test_defaults done");
   endtask

   task automatic test_rw();
      logic [2:0] sels [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
      int widths [5] = '{16, 16, 8, 24, 24};
      logic [31:0] vals [5] = '{32'h1234, 32'hA5C3, 32'h3C, 32'h123456, 32'hFEDCBA};
      for (int i = 0; i < 5; i++)
      begin
         wr({2'b00, sels[i], 3'b000}, widths[i], vals[i]);
         chk(reg_of(sels[i]), vals[i]);
         rd({2'b01, sels[i], 3'b000}, widths[i], v);
         chk(v, vals[i]);
      end
      wr(8'h20, 8, 32'hFF);
      wr(8'h00, 0, 32'h0);
      rd(8'h60, 8, v);
      chk(v, {24'h0, ID_VAL});
      $display("test_rw done");
   endtask

   task test_ready();
      pulse_res(24'hC3A55A);
      rd(8'h40, 8, v);
      chk(v, 32'h4D);
      rd(8'h58, 24, v);
      chk(v, 32'hC3A55A);
      chk({31'h0, ready_n_ff}, 32'h1);
      @(posedge core_clk);
      #1 power_down = 1'b1;
      pulse_res(24'h1);
      chk({31'h0, ready_n_ff}, 32'h1);
      power_down = 1'b0;
      pulse_res(24'h2);
      result_pending = 1'b1;
      pulse_res(24'h2);
      result_pending = 1'b0;
      rd(8'h40, 8, v);
      chk(v, 32'hCD);
      $display("test_ready done");
   endtask

   task test_cont();
      wr(8'h5C, 0, 32'h0);
      chk({31'h0, cont_read_ff}, 32'h1);
      pulse_res(24'h13579B);
      host_u.frame(64'h0, 24, rx);
      chk(rx[31:0], 32'h13579B);
      chk({31'h0, ready_n_ff}, 32'h1);
      pulse_res(24'h2468AC);
      wr(8'h58, 0, 32'h0);
      chk({31'h0, cont_read_ff}, 32'h0);
      rd(8'h58, 24, v);
      chk(v, 32'h2468AC);
      $display("test_cont done");
   endtask

   task test_line_reset();
      wr(8'h10, 16, 32'h5A5A);
      wr(8'h5C, 0, 32'h0);
      pr_seen = 1'b0;
      host_u.frame(64'hFFFFFFFF, 32, rx);
      chk({31'h0, pr_seen}, 32'h1);
      chk({31'h0, cont_read_ff}, 32'h0);
      chk({16'h0, chset}, 32'h0);
      rd(8'h48, 16, v);
      chk(v, 32'h000A);
      $display("test_line_reset done");
   endtask

   initial
   begin
      nrst = 1'b0;
      result_valid = 1'b0;
      result_data = 24'h0;
      result_pending = 1'b0;
      power_down = 1'b0;
      pr_seen = 1'b0;
      repeat (5) @(posedge core_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge core_clk);
      test_defaults();
      test_rw();
      test_ready();
      test_cont();
      test_line_reset();
      summarize();
   end
endmodule // test_serial_register_access_frontend
`default_nettype wire
